// ===== oled_panel_command_decoder.sv
// Command byte decoder for a passive-matrix panel controller, AXI4-Lite slave
// Notes on behaviour
// - Opcodes 00-1F load low or high nibble of page-mode column pointer.
// - Opcode 20 picks addressing mode; 10 at reset; 11 is refused.
// - Opcode 21 takes column window start and end, 0 to 131.
// - Opcode 22 takes page window start and end, 0 to 7.
// - Opcodes 40-7F load display start line from six low bits.
// - Opcode 81 sets base contrast, reset 80h.
// - Opcode 82 sets shared colour group brightness, reset 80h.
// - Opcode 91 takes four six-bit pulse widths; base and colour resets differ.
// - Opcodes 92 and 93 assign colours to groups 1-16 and 17-32.
// - A0 maps column 0 to first segment; A1 maps column 131 there.
// - A4/A5 follow RAM or light all; A6/A7 normal or inverse.
// - A8 sets multiplex ratio N+1; parameters 0 to 14 refused.
// - AB takes reserved byte, dim contrast, dim brightness.
// - AD bit 0 picks external supply or internal converter.
// - AE sleeps at reset; AF on normal; AC on dim.
// - B0-B7 load page-mode page start address.
// - C0 scans rows forward; C8 scans them in reverse.
// - D3 sets vertical shift 0 to 63, reset zero.
// - D5 low nibble divide ratio minus one, high nibble oscillator code.
// - D9 sets two pre-charge phases, reset 2, zero refused.
// - DA bit 4 alternative row order, bit 5 left/right remap.
// - E0 enters read-modify-write, EE leaves, E3 does nothing.
`timescale 1ns/1ps
module oled_panel_command_decoder #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  // Write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  // Read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Panel state
  output logic [1:0] disp_mode
);

  // ==========================================================
  // Elaboration check
  if (ADDR_W < 6) begin : g_bad_addr
    $error("ADDR_W must be at least 6");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [5:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] op;
    logic [2:0] left;
    logic [2:0] idx;
    logic [3:0] col_lo;
    logic [3:0] col_hi;
    logic [1:0] addr_mode;
    logic [7:0] col_start;
    logic [7:0] col_end;
    logic [2:0] page_start;
    logic [2:0] page_end;
    logic [2:0] page_ptr;
    logic [5:0] start_line;
    logic [7:0] contrast;
    logic [7:0] bright;
    logic [7:0] dim_contrast;
    logic [7:0] dim_bright;
    logic [5:0] pw_base;
    logic [5:0] pw_a;
    logic [5:0] pw_b;
    logic [5:0] pw_c;
    logic [31:0] bank_lo;
    logic [31:0] bank_hi;
    logic seg_remap;
    logic all_on;
    logic inverse;
    logic [5:0] multiplex_ratio;
    logic vcc_int;
    oled_cmd_pkg::disp_e disp;
    logic scan_rev;
    logic [5:0] offset;
    logic [3:0] clk_div;
    logic [3:0] osc;
    logic [3:0] pre1;
    logic [3:0] pre2;
    logic com_alt;
    logic com_lr;
    logic rmw;
    logic bad;
  } state_s;

  state_s state_ff;
  state_s nxt_state;

  // Parameter bytes that follow each opcode; unsupported ones are still counted
  function automatic logic [2:0] param_count(input logic [7:0] op);
    logic [2:0] n;
    n = 3'd0;
    if (op == oled_cmd_pkg::OP_PULSE || op == oled_cmd_pkg::OP_BANK_LO || op == oled_cmd_pkg::OP_BANK_HI) begin
      n = 3'd4;
    end else if (op == oled_cmd_pkg::OP_VSCROLL_R || op == oled_cmd_pkg::OP_VSCROLL_L) begin
      n = 3'd5;
    end else if (op == oled_cmd_pkg::OP_DIM) begin
      n = 3'd3;
    end else if (op == oled_cmd_pkg::OP_COL_WIN || op == oled_cmd_pkg::OP_PAGE_WIN
                 || op == oled_cmd_pkg::OP_SCROLL_AREA) begin
      n = 3'd2;
    end else if (op == oled_cmd_pkg::OP_ADDR_MODE || op == oled_cmd_pkg::OP_CONTRAST
                 || op == oled_cmd_pkg::OP_BRIGHT || op == oled_cmd_pkg::OP_MUX
                 || op == oled_cmd_pkg::OP_SUPPLY || op == oled_cmd_pkg::OP_OFFSET
                 || op == oled_cmd_pkg::OP_CLOCK || op == oled_cmd_pkg::OP_PRECHARGE
                 || op == oled_cmd_pkg::OP_ROW_CFG || op == oled_cmd_pkg::OP_AREA_MODE
                 || op == oled_cmd_pkg::OP_DESELECT) begin
      n = 3'd1;
    end
    return n;
  endfunction : param_count

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] b;
    b = state_ff.wdata[7:0];
    nxt_state = state_ff;

    // Bus handshakes
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (state_ff.awready && s_axi_awvalid) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.waddr = s_axi_awaddr[5:0];
    end
    if (state_ff.wready && s_axi_wvalid) begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = s_axi_wdata;
      nxt_state.wstrb = s_axi_wstrb;
    end

    // Write commit, one cycle after both halves are held
    if (state_ff.aw_got && state_ff.w_got) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = oled_cmd_pkg::RESP_OKAY;
      if (state_ff.waddr == oled_cmd_pkg::OFF_ERR) begin
        if (state_ff.wstrb[0] && state_ff.wdata[0]) begin
          nxt_state.bad = 1'b0;
        end
      end else if (state_ff.waddr == oled_cmd_pkg::OFF_CMD) begin
        if (state_ff.wstrb[0] && state_ff.left == 3'd0) begin
          nxt_state.op = b;
          nxt_state.idx = 3'd0;
          nxt_state.left = param_count(b);
          if (b[7:4] == oled_cmd_pkg::HI_COL_LO) begin
            nxt_state.col_lo = b[3:0];
          end else if (b[7:4] == oled_cmd_pkg::HI_COL_HI) begin
            nxt_state.col_hi = b[3:0];
          end else if (b[7:6] == oled_cmd_pkg::TOP_START_LINE) begin
            nxt_state.start_line = b[5:0];
          end else if (b[7:1] == oled_cmd_pkg::PAIR_SEG_REMAP) begin
            nxt_state.seg_remap = b[0];
          end else if (b[7:1] == oled_cmd_pkg::PAIR_ALL_ON) begin
            nxt_state.all_on = b[0];
          end else if (b[7:1] == oled_cmd_pkg::PAIR_INVERSE) begin
            nxt_state.inverse = b[0];
          end else if (b == oled_cmd_pkg::OP_DISP_DIM) begin
            nxt_state.disp = oled_cmd_pkg::DISP_DIM;
          end else if (b == oled_cmd_pkg::OP_DISP_OFF) begin
            nxt_state.disp = oled_cmd_pkg::DISP_OFF;
          end else if (b == oled_cmd_pkg::OP_DISP_ON) begin
            nxt_state.disp = oled_cmd_pkg::DISP_ON;
          end else if (b[7:3] == oled_cmd_pkg::TOP_PAGE_PTR) begin
            nxt_state.page_ptr = b[2:0];
          end else if (b == oled_cmd_pkg::OP_SCAN_FWD) begin
            nxt_state.scan_rev = 1'b0;
          end else if (b == oled_cmd_pkg::OP_SCAN_REV) begin
            nxt_state.scan_rev = 1'b1;
          end else if (b == oled_cmd_pkg::OP_RMW_ENTER) begin
            nxt_state.rmw = 1'b1;
          end else if (b == oled_cmd_pkg::OP_RMW_EXIT) begin
            nxt_state.rmw = 1'b0;
          end
        end else if (state_ff.wstrb[0]) begin
          nxt_state.idx = state_ff.idx + 3'd1;
          nxt_state.left = state_ff.left - 3'd1;
          case (state_ff.op)
            oled_cmd_pkg::OP_ADDR_MODE: begin
              if (b[1:0] == oled_cmd_pkg::ADDR_MODE_BAD) begin
                nxt_state.bad = 1'b1;
              end else begin
                nxt_state.addr_mode = b[1:0];
              end
            end
            oled_cmd_pkg::OP_COL_WIN: begin
              if (b > oled_cmd_pkg::COL_MAX) begin
                nxt_state.bad = 1'b1;
              end else if (state_ff.idx == 3'd0) begin
                nxt_state.col_start = b;
              end else begin
                nxt_state.col_end = b;
              end
            end
            oled_cmd_pkg::OP_PAGE_WIN: begin
              if (state_ff.idx == 3'd0) begin
                nxt_state.page_start = b[2:0];
              end else begin
                nxt_state.page_end = b[2:0];
              end
            end
            oled_cmd_pkg::OP_CONTRAST: begin
              nxt_state.contrast = b;
            end
            oled_cmd_pkg::OP_BRIGHT: begin
              nxt_state.bright = b;
            end
            oled_cmd_pkg::OP_PULSE: begin
              // pulse widths; short codes flagged but kept
              if (b[5:0] < oled_cmd_pkg::PW_MIN) begin
                nxt_state.bad = 1'b1;
              end
              case (state_ff.idx[1:0])
                2'd0: nxt_state.pw_base = b[5:0];
                2'd1: nxt_state.pw_a = b[5:0];
                2'd2: nxt_state.pw_b = b[5:0];
                default: nxt_state.pw_c = b[5:0];
              endcase
            end
            oled_cmd_pkg::OP_BANK_LO: begin
              nxt_state.bank_lo[{state_ff.idx[1:0], 3'b000} +: 8] = b;
            end
            oled_cmd_pkg::OP_BANK_HI: begin
              nxt_state.bank_hi[{state_ff.idx[1:0], 3'b000} +: 8] = b;
            end
            oled_cmd_pkg::OP_MUX: begin
              if (b[5:0] < oled_cmd_pkg::MUX_MIN) begin
                nxt_state.bad = 1'b1;
              end else begin
                nxt_state.multiplex_ratio = b[5:0];
              end
            end
            oled_cmd_pkg::OP_DIM: begin
              if (state_ff.idx == 3'd1) begin
                nxt_state.dim_contrast = b;
              end else if (state_ff.idx == 3'd2) begin
                nxt_state.dim_bright = b;
              end
            end
            oled_cmd_pkg::OP_SUPPLY: begin
              nxt_state.vcc_int = b[0];
            end
            oled_cmd_pkg::OP_OFFSET: begin
              nxt_state.offset = b[5:0];
            end
            oled_cmd_pkg::OP_CLOCK: begin
              nxt_state.clk_div = b[3:0];
              nxt_state.osc = b[7:4];
            end
            oled_cmd_pkg::OP_PRECHARGE: begin
              if (b[3:0] == 4'h0 || b[7:4] == 4'h0) begin
                nxt_state.bad = 1'b1;
              end else begin
                nxt_state.pre1 = b[3:0];
                nxt_state.pre2 = b[7:4];
              end
            end
            oled_cmd_pkg::OP_ROW_CFG: begin
              nxt_state.com_alt = b[4];
              nxt_state.com_lr = b[5];
            end
            default: begin
            end
          endcase
        end
      end else if (state_ff.waddr[1:0] != 2'b00 || state_ff.waddr > oled_cmd_pkg::OFF_ERR) begin
        nxt_state.bresp = oled_cmd_pkg::RESP_SLVERR;
      end
    end
    // One write at a time: ready drops while a write is held or answered
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid && !(state_ff.aw_got && state_ff.w_got);
    nxt_state.wready = !nxt_state.w_got && !nxt_state.bvalid && !(state_ff.aw_got && state_ff.w_got);

    // Read path
    if (state_ff.arready && s_axi_arvalid) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = oled_cmd_pkg::RESP_OKAY;
      nxt_state.rdata = 32'h0000_0000;
      if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_CMD) begin
        nxt_state.rdata = {21'h00_0000, state_ff.left, state_ff.op};
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_ADDR) begin
        nxt_state.rdata = {19'h0_0000, state_ff.page_ptr, state_ff.col_hi, state_ff.col_lo, state_ff.addr_mode};
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_WIN) begin
        nxt_state.rdata = {5'h00, state_ff.page_end, 5'h00, state_ff.page_start,
                           state_ff.col_end, state_ff.col_start};
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_DISP) begin
        nxt_state.rdata = {14'h0000, state_ff.rmw, state_ff.com_lr, state_ff.com_alt, state_ff.scan_rev,
                           state_ff.vcc_int, state_ff.disp, state_ff.inverse, state_ff.all_on,
                           state_ff.seg_remap, 2'b00, state_ff.start_line};
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_LEVEL) begin
        nxt_state.rdata = {state_ff.dim_bright, state_ff.dim_contrast, state_ff.bright, state_ff.contrast};
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_PULSE) begin
        nxt_state.rdata = {2'b00, state_ff.pw_c, 2'b00, state_ff.pw_b, 2'b00, state_ff.pw_a,
                           2'b00, state_ff.pw_base};
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_BANK_LO) begin
        nxt_state.rdata = state_ff.bank_lo;
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_BANK_HI) begin
        nxt_state.rdata = state_ff.bank_hi;
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_TIMING) begin
        nxt_state.rdata = {state_ff.pre2, state_ff.pre1, state_ff.osc, state_ff.clk_div,
                           2'b00, state_ff.offset, 2'b00, state_ff.multiplex_ratio};
      end else if (s_axi_araddr[5:0] == oled_cmd_pkg::OFF_ERR) begin
        nxt_state.rdata = {31'h0000_0000, state_ff.bad};
      end else begin
        nxt_state.rresp = oled_cmd_pkg::RESP_SLVERR;
      end
    end
    nxt_state.arready = !nxt_state.rvalid && !(state_ff.arready && s_axi_arvalid);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      nxt_state_reset();
    end else begin
      state_ff <= nxt_state;
    end
  end

  task automatic nxt_state_reset();
    state_ff <= '0;
    state_ff.addr_mode <= oled_cmd_pkg::RST_ADDR_MODE;
    state_ff.col_end <= oled_cmd_pkg::RST_COL_END;
    state_ff.page_end <= oled_cmd_pkg::RST_PAGE_END;
    state_ff.contrast <= oled_cmd_pkg::RST_LEVEL;
    state_ff.bright <= oled_cmd_pkg::RST_LEVEL;
    state_ff.pw_base <= oled_cmd_pkg::RST_PW_BASE;
    state_ff.pw_a <= oled_cmd_pkg::RST_PW_COLOR;
    state_ff.pw_b <= oled_cmd_pkg::RST_PW_COLOR;
    state_ff.pw_c <= oled_cmd_pkg::RST_PW_COLOR;
    state_ff.multiplex_ratio <= oled_cmd_pkg::RST_MUX;
    state_ff.osc <= oled_cmd_pkg::RST_OSC;
    state_ff.pre1 <= oled_cmd_pkg::RST_PRE;
    state_ff.pre2 <= oled_cmd_pkg::RST_PRE;
    state_ff.com_alt <= 1'b1;
  endtask : nxt_state_reset

  // ==========================================================
  // Outputs
  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready = state_ff.wready;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;
  assign disp_mode = state_ff.disp;

endmodule : oled_panel_command_decoder

// ===== oled_cmd_pkg.sv
// Constants and types for the panel command decoder
package oled_cmd_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] OFF_CMD = 6'h00;
  localparam logic [5:0] OFF_ADDR = 6'h04;
  localparam logic [5:0] OFF_WIN = 6'h08;
  localparam logic [5:0] OFF_DISP = 6'h0c;
  localparam logic [5:0] OFF_LEVEL = 6'h10;
  localparam logic [5:0] OFF_PULSE = 6'h14;
  localparam logic [5:0] OFF_BANK_LO = 6'h18;
  localparam logic [5:0] OFF_BANK_HI = 6'h1c;
  localparam logic [5:0] OFF_TIMING = 6'h20;
  localparam logic [5:0] OFF_ERR = 6'h24;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Reset values and limits
  localparam logic [1:0] RST_ADDR_MODE = 2'b10;
  localparam logic [1:0] ADDR_MODE_BAD = 2'b11;
  localparam logic [7:0] RST_COL_END = 8'h83;
  localparam logic [7:0] COL_MAX = 8'h83;
  localparam logic [2:0] RST_PAGE_END = 3'h7;
  localparam logic [7:0] RST_LEVEL = 8'h80;
  localparam logic [5:0] RST_PW_BASE = 6'h31;
  localparam logic [5:0] RST_PW_COLOR = 6'h3f;
  localparam logic [5:0] PW_MIN = 6'h1f;
  localparam logic [5:0] RST_MUX = 6'h3f;
  localparam logic [5:0] MUX_MIN = 6'h0f;
  localparam logic [3:0] RST_OSC = 4'h7;
  localparam logic [3:0] RST_PRE = 4'h2;

  // ==========================================================
  // Opcodes with parameters
  localparam logic [7:0] OP_ADDR_MODE = 8'h20;
  localparam logic [7:0] OP_COL_WIN = 8'h21;
  localparam logic [7:0] OP_PAGE_WIN = 8'h22;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_BRIGHT = 8'h82;
  localparam logic [7:0] OP_PULSE = 8'h91;
  localparam logic [7:0] OP_BANK_LO = 8'h92;
  localparam logic [7:0] OP_BANK_HI = 8'h93;
  localparam logic [7:0] OP_MUX = 8'ha8;
  localparam logic [7:0] OP_DIM = 8'hab;
  localparam logic [7:0] OP_SUPPLY = 8'had;
  localparam logic [7:0] OP_OFFSET = 8'hd3;
  localparam logic [7:0] OP_CLOCK = 8'hd5;
  localparam logic [7:0] OP_PRECHARGE = 8'hd9;
  localparam logic [7:0] OP_ROW_CFG = 8'hda;
  localparam logic [7:0] OP_AREA_MODE = 8'hd8;
  localparam logic [7:0] OP_DESELECT = 8'hdb;
  localparam logic [7:0] OP_SCROLL_AREA = 8'ha3;
  localparam logic [7:0] OP_VSCROLL_R = 8'h29;
  localparam logic [7:0] OP_VSCROLL_L = 8'h2a;

  // ==========================================================
  // Single-byte opcodes
  localparam logic [3:0] HI_COL_LO = 4'h0;
  localparam logic [3:0] HI_COL_HI = 4'h1;
  localparam logic [1:0] TOP_START_LINE = 2'b01;
  localparam logic [6:0] PAIR_SEG_REMAP = 7'h50;
  localparam logic [6:0] PAIR_ALL_ON = 7'h52;
  localparam logic [6:0] PAIR_INVERSE = 7'h53;
  localparam logic [4:0] TOP_PAGE_PTR = 5'h16;
  localparam logic [7:0] OP_DISP_DIM = 8'hac;
  localparam logic [7:0] OP_DISP_OFF = 8'hae;
  localparam logic [7:0] OP_DISP_ON = 8'haf;
  localparam logic [7:0] OP_SCAN_FWD = 8'hc0;
  localparam logic [7:0] OP_SCAN_REV = 8'hc8;
  localparam logic [7:0] OP_RMW_ENTER = 8'he0;
  localparam logic [7:0] OP_RMW_EXIT = 8'hee;

  // ==========================================================
  // Display power state
  typedef enum logic [1:0] {
    DISP_OFF = 2'b00,
    DISP_ON = 2'b01,
    DISP_DIM = 2'b10
  } disp_e;

endpackage : oled_cmd_pkg

// ===== oled_panel_command_decoder_properties.sv
// Bus timing and display state checks for the command decoder
`timescale 1ns/1ps
module oled_decoder_checker (
  // Clock, reset, panel state
  input wire logic clk, rst,
  input wire logic [1:0] disp_mode,
  // Write channels
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Steps of a write
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_commit;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_write_answer; s_both_taken |=> s_commit; endproperty
  property p_b_holds; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_ready_back; s_axi_bvalid && s_axi_bready |=> ##[0:1] s_axi_awready; endproperty
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_holds; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_one_write; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_one_read; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_disp_legal; disp_mode != 2'b11; endproperty
  property p_disp_at_commit; !$stable(disp_mode) |-> $rose(s_axi_bvalid); endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not committed in time");
  a_b_holds: assert property (p_b_holds) else $error("write answer dropped");
  a_ready_back: assert property (p_ready_back) else $error("write ready not restored");
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_r_holds: assert property (p_r_holds) else $error("read answer dropped");
  a_one_write: assert property (p_one_write) else $error("second write accepted");
  a_one_read: assert property (p_one_read) else $error("second read accepted");
  a_disp_legal: assert property (p_disp_legal) else $error("bad display state");
  a_disp_at_commit: assert property (p_disp_at_commit) else $error("display changed off commit");
endmodule : oled_decoder_checker

bind oled_panel_command_decoder oled_decoder_checker chk (.*);

// ===== oled_host_model.sv
// Host that issues register accesses, optionally slow to take answers
`timescale 1ns/1ps
module oled_host_model (
  // Clock and pacing
  input wire logic clk,
  input wire logic slow,
  // Write channels
  output logic s_axi_awvalid = 1'b0,
  output logic [5:0] s_axi_awaddr = 6'h00,
  output logic s_axi_wvalid = 1'b0,
  output logic [31:0] s_axi_wdata = 32'h0000_0000,
  output logic [3:0] s_axi_wstrb = 4'hf,
  output logic s_axi_bready = 1'b0,
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  output logic s_axi_arvalid = 1'b0,
  output logic [5:0] s_axi_araddr = 6'h00,
  output logic s_axi_rready = 1'b0,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // ==========================================
  // Write; released payload is scrambled so stale values cannot pass
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= !slow || s_axi_bvalid;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // ==========================================
  // Read
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= !slow || s_axi_rvalid;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : oled_host_model

// ===== test_oled_panel_command_decoder.sv
// Self-checking bench for the panel command decoder
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; $display("mismatch %0t %h %h", $time, a, e); end end
module test_oled_panel_command_decoder;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, val;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, disp_mode, resp;
  int failures = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  oled_panel_command_decoder #(.ADDR_W(6)) uut (.*);
  oled_host_model host (.*);

  // ==========================================
  // Access helpers
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      host.wr(6'h00, {24'h00_0000, q[i]}, resp);
      `CHK(resp, 2'b00)
    end
  endtask : send
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    host.rd(a, val, resp);
    `CHK({resp, val}, {2'b00, e})
  endtask : rd_chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================
  // Command sequences
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(disp_mode, 2'b00)
    rd_chk(6'h04, 32'h0000_0002);
    rd_chk(6'h08, 32'h0700_8300);
    rd_chk(6'h0c, 32'h0000_8000);
    rd_chk(6'h10, 32'h0000_8080);
    rd_chk(6'h14, 32'h3f3f_3f31);
    rd_chk(6'h20, 32'h2270_003f);
    send({8'h20, 8'h03, 8'h20, 8'h00, 8'h0a, 8'h1c, 8'hb5});
    rd_chk(6'h04, 32'h0000_1728);
    rd_chk(6'h24, 32'h0000_0001);
    host.wr(6'h24, 32'h0000_0001, resp);
    `CHK(resp, 2'b00)
    send({8'ha8, 8'h0e});
    rd_chk(6'h24, 32'h0000_0001);
    host.wr(6'h24, 32'h0000_0001, resp);
    `CHK(resp, 2'b00)
    send({8'ha8, 8'h0f, 8'hd3, 8'h3f, 8'hd5, 8'h51, 8'hd9, 8'hf1});
    rd_chk(6'h20, 32'hf151_3f0f);
    rd_chk(6'h24, 32'h0000_0000);
    send({8'h21, 8'h05, 8'h64, 8'h22, 8'h02, 8'h06});
    rd_chk(6'h08, 32'h0602_6405);
    // Reserved first byte sent as zeros
    send({8'h81, 8'h10, 8'h82, 8'h20, 8'hab, 8'h00, 8'h12, 8'h34});
    rd_chk(6'h10, 32'h3412_2010);
    send({8'h91, 8'h1f, 8'h20, 8'h2a, 8'h3f});
    rd_chk(6'h14, 32'h3f2a_201f);
    send({8'h92, 8'h1b, 8'he4, 8'h00, 8'hc0, 8'h93, 8'hff, 8'h00, 8'h00, 8'h01});
    rd_chk(6'h18, 32'hc000_e41b);
    rd_chk(6'h1c, 32'h0100_00ff);
    // Slow host from here to hold answers up
    slow <= 1'b1;
    send({8'h47, 8'ha1, 8'ha5, 8'ha7, 8'hc8, 8'hda, 8'h22, 8'he0});
    // Converter enable order
    send({8'had, 8'h8f, 8'haf});
    `CHK(disp_mode, 2'b01)
    rd_chk(6'h0c, 32'h0003_6f07);
    send({8'hac});
    `CHK(disp_mode, 2'b10)
    send({8'he3, 8'hee, 8'ha0, 8'ha4, 8'ha6, 8'hc0, 8'hae});
    `CHK(disp_mode, 2'b00)
    rd_chk(6'h0c, 32'h0001_2007);
    // Unsupported opcodes still swallow their parameter bytes
    send({8'h29, 8'h41, 8'hc8, 8'ha7, 8'haf});
    rd_chk(6'h00, 32'h0000_0129);
    send({8'h44, 8'hdb, 8'ha1, 8'hd8, 8'haf});
    rd_chk(6'h00, 32'h0000_00d8);
    rd_chk(6'h0c, 32'h0001_2007);
    host.wr(6'h28, 32'h0000_00af, resp);
    `CHK(resp, 2'b10)
    host.rd(6'h02, val, resp);
    `CHK(resp, 2'b10)
    `CHK(disp_mode, 2'b00)
    wrap_up();
  end
endmodule : test_oled_panel_command_decoder
